// ===== common/tx_cmd_pkg.sv
// Purpose: Shared constants and carrier types for the transmitter command
//          interpreter and its bit queue.
// Assumes: 100 MHz system clock, 10 MHz crystal reference.
// Notes:   Command words are 16 bits; the queue-load code is 8 bits.
package tx_cmd_pkg;

  // Clocking and bit-rate base
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int REF_CLK_HZ = 10_000_000;
  localparam int RATE_PRESCALE = 29;
  localparam int BIT_UNIT_CYCLES = SYS_CLK_HZ / REF_CLK_HZ * RATE_PRESCALE;
  localparam int TX_QUEUE_BITS = 64;

  // Pin synchroniser lanes
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_MOD = 3;
  localparam logic [3:0] PIN_IDLE = 4'h1;

  // Serial framing
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] WORD_LAST = 4'hF;

  // Command codes
  localparam logic [3:0] CODE_CFG = 4'h9;
  localparam logic [3:0] CODE_FREQ = 4'hA;
  localparam logic [3:0] CODE_WAKE = 4'hE;
  localparam logic [7:0] CODE_PWR = 8'hC0;
  localparam logic [7:0] CODE_QLOAD = 8'hC6;
  localparam logic [7:0] CODE_QSET = 8'hCE;
  localparam logic [7:0] CODE_RATE = 8'hC8;
  localparam logic [7:0] CODE_LBCLK = 8'hC2;
  localparam logic [7:0] CODE_WAKEX = 8'hC3;
  localparam logic [7:0] CODE_FEAT = 8'hB0;

  // Power-on values
  localparam logic [15:0] POR_CFG = 16'h9082;
  localparam logic [15:0] POR_FREQ = 16'hAD57;
  localparam logic [15:0] POR_PWR = 16'hC002;
  localparam logic [15:0] POR_QSET = 16'hCE00;
  localparam logic [15:0] POR_RATE = 16'hC813;
  localparam logic [15:0] POR_LBCLK = 16'hC213;
  localparam logic [15:0] POR_WAKE = 16'hE196;
  localparam logic [15:0] POR_WAKEX = 16'hC300;
  localparam logic [15:0] POR_FEAT = 16'hB0CA;

  // Field positions
  localparam int CFG_BAND = 11;
  localparam int CFG_POWER = 8;
  localparam int CFG_LOAD = 4;
  localparam int CFG_DEVSIGN = 3;
  localparam int CFG_DEVMAG = 0;
  localparam int PWR_OSC = 5;
  localparam int PWR_SYNTH = 4;
  localparam int PWR_PA = 3;
  localparam int PWR_BATT = 2;
  localparam int PWR_WAKE = 1;
  localparam int PWR_CLKDIS = 0;
  localparam int QSET_EN = 7;
  localparam int QSET_LEVEL = 0;
  localparam int RATE_PRE = 7;
  localparam int RATE_DIV = 0;
  localparam int LB_DIV = 5;
  localparam int LB_SLOW = 4;
  localparam int LB_THRESH = 0;
  localparam int WAKE_EXP = 8;
  localparam int WAKE_MLO = 0;
  localparam int WAKEX_DIV = 6;
  localparam int WAKEX_MHI = 0;
  localparam int FEAT_XLP = 7;
  localparam int FEAT_TAIL = 6;
  localparam int FEAT_NOCAL = 4;
  localparam int FEAT_BW = 2;
  localparam int FEAT_HOLD = 1;
  localparam int FEAT_AUTOWAKE = 0;

  // Derived settings
  localparam logic [11:0] CH_MIN = 12'h060;
  localparam logic [11:0] CH_MAX = 12'hF3F;
  localparam logic [15:0] BASE_LOW_BAND = 16'h9C40;
  localparam logic [15:0] BASE_HIGH_BAND = 16'hABE0;
  localparam logic [4:0] ATTEN_STEP_DB = 5'h03;
  localparam logic [5:0] LOAD_CAP_BASE = 6'h11;
  localparam logic [5:0] BATT_BASE = 6'h14;
  localparam logic [9:0] TAIL_LONG = 10'h200;
  localparam logic [9:0] TAIL_SHORT = 10'h080;
  localparam logic [3:0] PRESCALE_HIGH = 4'h8;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_IDLE = 2'b10,
    MODE_ACTIVE = 2'b11
  } mode_type;

  typedef enum logic {
    SER_CMD = 1'b0,
    SER_LOAD = 1'b1
  } serial_state_type;

  typedef struct packed {
    logic bandSelect;
    logic [15:0] synthWord;
    logic [4:0] powerAttenDb;
    logic [5:0] loadCapHalfPf;
    logic devSign;
    logic [3:0] devSteps;
    logic [1:0] loopBandwidth;
    logic oscLowPower;
  } rf_settings_type;

  typedef struct packed {
    logic oscOn;
    logic synthOn;
    logic paOn;
    logic batteryDetectEnable;
    logic wakeTimerEnable;
    logic clockOutEnable;
    mode_type mode;
  } power_state_type;

  typedef struct packed {
    logic [2:0] mcuClockDiv;
    logic fastClockValid;
    logic slowClockSel;
    logic [9:0] tailCycles;
    logic [5:0] batteryThreshDeciV;
    logic [13:0] wakeMantissa;
    logic [3:0] wakeExponent;
    logic [1:0] wakeDivisor;
    logic calibDisable;
    logic autoWakeOnIrq;
    logic holdAwakeAfterQueueIrq;
  } clock_wake_type;

endpackage

// ===== logic/tx_bit_queue.sv
// Purpose: Small first-in first-out store for transmit data bits.
// Assumes: DEPTH is a power of two; one write and one pop per cycle at most.
// Notes:   Read data is registered, so valid lags a write by two cycles.
`timescale 1ns/1ps
module tx_bit_queue
  import tx_cmd_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = TX_QUEUE_BITS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic wrValid,
  input wire logic [WIDTH-1:0] wrData,
  output logic wrReady,
  input wire logic rdPop,
  output logic rdValid,
  output logic [WIDTH-1:0] rdData,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("tx_bit_queue: WIDTH >= 1 and power-of-two DEPTH required");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;

  wire doWrite = wrValid && wrReady && !flush;
  wire doPop = rdPop && rdValid && !flush;
  wire [AW:0] next_count = count + {{AW{1'b0}}, doWrite}
                         - {{AW{1'b0}}, doPop};
  assign wrReady = count != (AW + 1)'(DEPTH);

  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr] <= wrData;
    end
  end

  // Valid drops for a cycle after each pop while the read register refills
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      rdValid <= 1'b0;
      rdData <= '0;
    end else if (flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      rdValid <= 1'b0;
    end else begin
      wrPtr <= wrPtr + AW'(doWrite);
      rdPtr <= rdPtr + AW'(doPop);
      count <= next_count;
      rdValid <= (count != '0) && !doPop;
      rdData <= mem[rdPtr];
    end
  end

endmodule

// ===== logic/tx_command_interpreter.sv
// Purpose: Serial command decoder and control registers of an FSK transmitter.
// Assumes: Serial pins are asynchronous; each passes a three-stage filter.
// Notes:   Settings leave on registered structs, two cycles after decode.
// Notes on behaviour
// [RL1] Select low shifts bits MSB first; high resets.
// [RL2] Center frequency from band constant plus channel.
// [RL3] Power code lowers output in 3 dB steps.
// [RL4] Load capacitance 8.5 pF plus half-pF steps.
// [RL5] Deviation sign is sign bit XOR modulation.
// [RL6] Channel outside 96..3903 keeps previous value.
// [RL7] Power word holds six enables, default C002h.
// [RL8] Amplifier enable forces oscillator and synthesizer on.
// [RL9] Amplifier enable in queue mode rolls out bits.
// [RL10] Operating mode derived from the enable bits.
// [RL11] Host should toggle only amplifier for speed.
// [RL12] Queue load accepted only while queue enabled.
// [RL13] Host enables amplifier before direct modulation.
// [RL14] Clearing queue enable empties the queue.
// [RL15] Pulse when remaining bits reach programmed level.
// [RL16] Bit period from divisor and prescale bit.
// [RL17] Battery threshold 2.0 V plus tenth-volt steps.
// [RL18] Slow clock out in sleep when enabled.
// [RL19] Clock divider valid only while oscillator runs.
// [RL20] Wake period from mantissa, exponent and divisor.
// [RL21] Clock tail 512 cycles when selected, else 128.
// [RL22] Loop bandwidth field and oscillator low power.
// [RL23] Calibration disable stops wake timer recalibration.
// [RL24] Auto wake on interrupt; hold awake option.
// [RL25] Register updates only after complete word.
`timescale 1ns/1ps
module tx_command_interpreter
  import tx_cmd_pkg::*;
#(
  parameter int QUEUE_DEPTH = TX_QUEUE_BITS,
  parameter int BIT_BASE_CYCLES = BIT_UNIT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic chipSelectN,
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic modulationIn,
  output rf_settings_type rfOut,
  output power_state_type powerOut,
  output clock_wake_type clockWakeOut,
  output logic txBit,
  output logic txActive,
  output logic queueLevelIrq,
  output logic queueFull
);
  localparam int CW = $clog2(QUEUE_DEPTH) + 1;

  // Level field is six bits, so the count must hold at least 64
  if (QUEUE_DEPTH < 64 || (QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0
      || BIT_BASE_CYCLES < 2 || BIT_BASE_CYCLES > 1023) begin : g_chk
    $error("tx_command_interpreter: unsupported parameter values");
  end

  // Pin filter: a level counts once stages two and three agree
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic [3:0] syncC;
  logic [3:0] pinStable;
  wire [3:0] pinRaw = {modulationIn, serialDataIn, serialClock, chipSelectN};
  wire [3:0] pinAgree = ~(syncB ^ syncC);
  wire [3:0] next_pinStable = (pinAgree & syncC) | (~pinAgree & pinStable);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= PIN_IDLE;
      syncB <= PIN_IDLE;
      syncC <= PIN_IDLE;
      pinStable <= PIN_IDLE;
    end else begin
      syncA <= pinRaw;
      syncB <= syncA;
      syncC <= syncB;
      pinStable <= next_pinStable;
    end
  end

  wire csActive = ~next_pinStable[PIN_CS];
  wire sckRise = csActive & ~pinStable[PIN_SCK] & next_pinStable[PIN_SCK];
  wire sdiBit = next_pinStable[PIN_SDI];
  wire modPin = pinStable[PIN_MOD];

  // Serial framing
  serial_state_type serState;
  logic [15:0] shiftReg;
  logic [3:0] bitCount;
  logic cmdValid;
  logic [15:0] cmdWord;
  wire [15:0] shiftNext = {shiftReg[14:0], sdiBit};
  wire queueLoadCode = (bitCount == BYTE_LAST)
                     && (shiftNext[7:0] == CODE_QLOAD);
  wire wordDone = bitCount == WORD_LAST;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serState <= SER_CMD;
      shiftReg <= '0;
      bitCount <= '0;
      cmdValid <= 1'b0;
      cmdWord <= '0;
    end else begin
      cmdValid <= 1'b0;
      // [RL1] Select high restarts
      if (!csActive) begin
        serState <= SER_CMD;
        bitCount <= '0;
      end else if (sckRise) begin
        case (serState)
          SER_CMD: begin
            // [RL1] MSB first shift
            shiftReg <= shiftNext;
            bitCount <= bitCount + 4'h1;
            if (queueLoadCode) begin
              serState <= SER_LOAD;
            end
            // [RL25] Whole word strobe
            if (wordDone) begin
              cmdValid <= 1'b1;
              cmdWord <= shiftNext;
            end
          end
          SER_LOAD: begin
            serState <= SER_LOAD;
          end
          default: begin
            serState <= SER_CMD;
          end
        endcase
      end
    end
  end

  // Command decode
  wire [7:0] cmdHigh = cmdWord[15:8];
  wire [11:0] cmdChannel = cmdWord[11:0];
  // [RL6] Channel range check
  wire chInRange = (cmdChannel >= CH_MIN) && (cmdChannel <= CH_MAX);
  wire isCfg = cmdValid && (cmdWord[15:12] == CODE_CFG);
  wire isFreq = cmdValid && (cmdWord[15:12] == CODE_FREQ) && chInRange;
  wire isWake = cmdValid && (cmdWord[15:12] == CODE_WAKE);
  wire isPwr = cmdValid && (cmdHigh == CODE_PWR);
  wire isQset = cmdValid && (cmdHigh == CODE_QSET);
  wire isRate = cmdValid && (cmdHigh == CODE_RATE);
  wire isLbclk = cmdValid && (cmdHigh == CODE_LBCLK);
  wire isWakex = cmdValid && (cmdHigh == CODE_WAKEX);
  wire isFeat = cmdValid && (cmdHigh == CODE_FEAT);

  logic [15:0] cfgWord;
  logic [15:0] freqWord;
  logic [15:0] pwrWord;
  logic [15:0] qsetWord;
  logic [15:0] rateWord;
  logic [15:0] lbclkWord;
  logic [15:0] wakeWord;
  logic [15:0] wakexWord;
  logic [15:0] featWord;

  // [RL7] Power-on defaults
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgWord <= POR_CFG;
      freqWord <= POR_FREQ;
      pwrWord <= POR_PWR;
      qsetWord <= POR_QSET;
      rateWord <= POR_RATE;
      lbclkWord <= POR_LBCLK;
      wakeWord <= POR_WAKE;
      wakexWord <= POR_WAKEX;
      featWord <= POR_FEAT;
    end else begin
      // [RL25] Decoded word updates
      if (isCfg) cfgWord <= cmdWord;
      if (isFreq) freqWord <= cmdWord;
      if (isPwr) pwrWord <= cmdWord;
      if (isQset) qsetWord <= cmdWord;
      if (isRate) rateWord <= cmdWord;
      if (isLbclk) lbclkWord <= cmdWord;
      if (isWake) wakeWord <= cmdWord;
      if (isWakex) wakexWord <= cmdWord;
      if (isFeat) featWord <= cmdWord;
    end
  end

  // Field extraction
  wire oscBit = pwrWord[PWR_OSC];
  wire synthBit = pwrWord[PWR_SYNTH];
  wire paBit = pwrWord[PWR_PA];
  wire battBit = pwrWord[PWR_BATT];
  wire wakeBit = pwrWord[PWR_WAKE];
  wire queueEnable = qsetWord[QSET_EN];
  wire [5:0] irqLevel = qsetWord[QSET_LEVEL +: 6];
  wire [6:0] rateDiv = rateWord[RATE_DIV +: 7];
  wire ratePre = rateWord[RATE_PRE];

  // [RL8] Amplifier pulls oscillator and synthesizer on
  wire oscOn = oscBit | paBit;
  wire synthOn = synthBit | paBit;

  // [RL10] Mode priority chain
  wire mode_type next_mode = paBit ? MODE_ACTIVE
                           : (oscBit | synthBit) ? MODE_IDLE
                           : (battBit | wakeBit) ? MODE_SLEEP
                           : MODE_STANDBY;

  // Bit queue
  logic qWrReady;
  logic qRdValid;
  logic qRdData;
  logic [CW-1:0] qCount;
  logic qPop;
  // [RL14] Disabled queue is held empty
  wire queueFlush = !queueEnable;
  // [RL12] Load only while enabled
  wire qWrValid = sckRise && (serState == SER_LOAD) && queueEnable;

  tx_bit_queue #(
    .WIDTH(1),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flush(queueFlush),
    .wrValid(qWrValid),
    .wrData(sdiBit),
    .wrReady(qWrReady),
    .rdPop(qPop),
    .rdValid(qRdValid),
    .rdData(qRdData),
    .count(qCount)
  );

  // Bit timer: period in system cycles, less one
  function automatic logic [19:0] bitPeriod(input logic [6:0] r,
                                            input logic pre);
    logic [19:0] base;
    logic [19:0] scaled;
    base = 20'(BIT_BASE_CYCLES) * ({13'h0000, r} + 20'h00001);
    scaled = pre ? 20'(base * {16'h0000, PRESCALE_HIGH}) : base;
    return scaled - 20'h00001;
  endfunction

  logic [19:0] rateCount;
  // [RL9] Roll-out needs amplifier and queue mode
  wire txRunning = paBit && queueEnable;
  wire rateTick = txRunning && (rateCount == 20'h00000);
  assign qPop = rateTick && qRdValid;
  // [RL15] Remaining bits after this pop
  wire levelHit = qPop && ((qCount - CW'(1)) == CW'(irqLevel));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rateCount <= '0;
      txBit <= 1'b0;
      txActive <= 1'b0;
      queueLevelIrq <= 1'b0;
    end else begin
      // [RL16] Bit rate divider
      if (!txRunning) begin
        rateCount <= '0;
      end else if (rateTick) begin
        rateCount <= bitPeriod(rateDiv, ratePre);
      end else begin
        rateCount <= rateCount - 20'h00001;
      end
      // [RL9] Shift out stored bits
      if (qPop) begin
        txBit <= qRdData;
      end
      txActive <= txRunning;
      queueLevelIrq <= levelHit;
    end
  end

  assign queueFull = !qWrReady;

  // Output assembly; modulation follows the queue in queue mode
  wire modBit = queueEnable ? txBit : modPin;
  wire [2:0] powerCode = cfgWord[CFG_POWER +: 3];
  wire [3:0] loadCode = cfgWord[CFG_LOAD +: 4];
  wire [2:0] devMag = cfgWord[CFG_DEVMAG +: 3];
  wire bandSel = cfgWord[CFG_BAND];
  rf_settings_type next_rfOut;
  power_state_type next_powerOut;
  clock_wake_type next_clockWakeOut;

  // [RL2] Band base plus channel
  assign next_rfOut.bandSelect = bandSel;
  assign next_rfOut.synthWord = (bandSel ? BASE_HIGH_BAND : BASE_LOW_BAND)
                              + {4'h0, freqWord[11:0]};
  // [RL3] Attenuation in dB
  assign next_rfOut.powerAttenDb = {2'b00, powerCode} * ATTEN_STEP_DB;
  // [RL4] Load in half picofarads
  assign next_rfOut.loadCapHalfPf = LOAD_CAP_BASE + {2'b00, loadCode};
  // [RL5] Deviation sign and step count
  assign next_rfOut.devSign = cfgWord[CFG_DEVSIGN] ^ modBit;
  assign next_rfOut.devSteps = {1'b0, devMag} + 4'h1;
  // [RL22] Loop bandwidth and low power
  assign next_rfOut.loopBandwidth = featWord[FEAT_BW +: 2];
  assign next_rfOut.oscLowPower = featWord[FEAT_XLP];

  // [RL7] Six enables
  assign next_powerOut.oscOn = oscOn;
  assign next_powerOut.synthOn = synthOn;
  assign next_powerOut.paOn = paBit;
  assign next_powerOut.batteryDetectEnable = battBit;
  assign next_powerOut.wakeTimerEnable = wakeBit;
  assign next_powerOut.clockOutEnable = !pwrWord[PWR_CLKDIS];
  assign next_powerOut.mode = next_mode;

  // [RL19] Divider valid with oscillator
  assign next_clockWakeOut.mcuClockDiv = lbclkWord[LB_DIV +: 3];
  assign next_clockWakeOut.fastClockValid = oscOn;
  // [RL18] Slow clock only in sleep
  assign next_clockWakeOut.slowClockSel = lbclkWord[LB_SLOW]
                                        && (next_mode == MODE_SLEEP);
  // [RL21] Tail length select
  assign next_clockWakeOut.tailCycles = featWord[FEAT_TAIL] ? TAIL_LONG
                                                            : TAIL_SHORT;
  // [RL17] Threshold in tenths of a volt
  assign next_clockWakeOut.batteryThreshDeciV = BATT_BASE
                                              + {2'b00,
                                                 lbclkWord[LB_THRESH +: 4]};
  // [RL20] Mantissa joined from two words
  assign next_clockWakeOut.wakeMantissa = {wakexWord[WAKEX_MHI +: 6],
                                           wakeWord[WAKE_MLO +: 8]};
  assign next_clockWakeOut.wakeExponent = wakeWord[WAKE_EXP +: 4];
  assign next_clockWakeOut.wakeDivisor = wakexWord[WAKEX_DIV +: 2];
  // [RL23] Calibration disable
  assign next_clockWakeOut.calibDisable = featWord[FEAT_NOCAL];
  // [RL24] Wake and hold options
  assign next_clockWakeOut.autoWakeOnIrq = featWord[FEAT_AUTOWAKE];
  assign next_clockWakeOut.holdAwakeAfterQueueIrq = featWord[FEAT_HOLD];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rfOut <= '0;
      powerOut <= '0;
      clockWakeOut <= '0;
    end else begin
      rfOut <= next_rfOut;
      powerOut <= next_powerOut;
      clockWakeOut <= next_clockWakeOut;
    end
  end

  // Checks
  cs_reinit_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_n)
    !csActive |=> (bitCount == 4'h0) && (serState == SER_CMD))
    else $error("serial state not cleared by deselect");

  channel_keep_a: assert property ( // RL6
    @(posedge sys_clk) disable iff (!rst_n)
    (cmdValid && cmdWord[15:12] == CODE_FREQ && !chInRange)
    |=> $stable(freqWord))
    else $error("out-of-range channel was stored");

  pa_forces_a: assert property ( // RL8
    @(posedge sys_clk) disable iff (!rst_n)
    paBit |=> powerOut.oscOn && powerOut.synthOn)
    else $error("amplifier on without oscillator and synthesizer");

  mode_active_a: assert property ( // RL10
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(paBit) |=> (powerOut.mode == MODE_ACTIVE)[*2])
    else $error("mode not active with amplifier enabled");

  queue_load_a: assert property ( // RL12
    @(posedge sys_clk) disable iff (!rst_n)
    (sckRise && serState == SER_LOAD && !queueEnable)
    |=> $stable(qCount))
    else $error("queue written while disabled");

  queue_flush_a: assert property ( // RL14
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(queueEnable) |=> (qCount == '0) && !qRdValid)
    else $error("queue not emptied on disable");

  level_irq_a: assert property ( // RL15
    @(posedge sys_clk) disable iff (!rst_n)
    (qPop && qCount == CW'(irqLevel) + CW'(1))
    |=> queueLevelIrq ##1 !queueLevelIrq)
    else $error("level pulse missing or too long");

  rollout_bit_a: assert property ( // RL9
    @(posedge sys_clk) disable iff (!rst_n)
    qPop |=> (txBit == $past(qRdData)) && (rateCount != 20'h00000))
    else $error("queued bit not shifted out");

  word_only_a: assert property ( // RL25
    @(posedge sys_clk) disable iff (!rst_n)
    !$stable(cfgWord) |-> $past(cmdValid) && $past(cmdWord[15:12]) == CODE_CFG)
    else $error("register changed without a complete word");

  slow_clock_a: assert property ( // RL18
    @(posedge sys_clk) disable iff (!rst_n)
    clockWakeOut.slowClockSel |-> powerOut.mode == MODE_SLEEP)
    else $error("slow clock selected outside sleep");

endmodule

// ===== verif/serial_host_model.sv
// Purpose: Host model driving the serial command pins.
// Assumes: Pins change on falling sys_clk edges only.
// Notes: Data line has no pull, so it flips when the frame ends.
`timescale 1ns/1ps
module serial_host_model (
  input wire logic sys_clk,
  output logic chipSelectN,
  output logic serialClock,
  output logic serialDataIn
);
  initial begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
  end
  task automatic shift(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge sys_clk) chipSelectN <= 1'b0;
      serialDataIn <= v[i];
      // Five cycles each phase so the pin filter sees every level
      repeat (5) @(negedge sys_clk);
      serialClock <= 1'b1;
      repeat (5) @(negedge sys_clk);
      serialClock <= 1'b0;
    end
  endtask
  task automatic close();
    repeat (3) @(negedge sys_clk);
    chipSelectN <= 1'b1;
    serialDataIn <= ~serialDataIn;
    repeat (12) @(negedge sys_clk);
  endtask
endmodule

// ===== verif/test_tx_command_interpreter.sv
// Purpose: Self-checking bench for the command interpreter.
// Assumes: Short bit period (BIT_BASE_CYCLES=2) for quick runs.
// Notes: Queue tests use rate word C800, one bit per two cycles.
`timescale 1ns/1ps
module test_tx_command_interpreter;
  import tx_cmd_pkg::*;
  logic sys_clk, rst_n, chipSelectN, serialClock, serialDataIn;
  logic modulationIn, txBit, txActive, queueLevelIrq, queueFull;
  rf_settings_type rfOut;
  power_state_type powerOut;
  clock_wake_type clockWakeOut;
  int num_errors = 0;
  int checks_done = 0;
  int irqCount = 0;
  logic [15:0] pw [4] = '{16'hC008, 16'hC020, 16'hC004, 16'hC000};
  mode_type md [4] = '{MODE_ACTIVE, MODE_IDLE, MODE_SLEEP, MODE_STANDBY};

  tx_command_interpreter #(.BIT_BASE_CYCLES(2)) DUT (.sys_clk(sys_clk),
    .rst_n(rst_n), .chipSelectN(chipSelectN), .serialClock(serialClock),
    .serialDataIn(serialDataIn), .modulationIn(modulationIn),
    .rfOut(rfOut), .powerOut(powerOut), .clockWakeOut(clockWakeOut),
    .txBit(txBit), .txActive(txActive), .queueLevelIrq(queueLevelIrq),
    .queueFull(queueFull));
  serial_host_model HOST (.sys_clk(sys_clk), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .serialDataIn(serialDataIn));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (queueLevelIrq === 1'b1) irqCount++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [15:0] w);
    HOST.shift(w, 16);
    HOST.close();
  endtask
  task automatic load(input logic [15:0] b, input int n);
    HOST.shift(16'h00C6, 8);
    HOST.shift(b, n);
    HOST.close();
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    modulationIn = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(rfOut.synthWord, 16'hA997);
    chk(rfOut.loadCapHalfPf, 16'h0019);
    chk(rfOut.devSteps, 16'h0003);
    chk(rfOut.loopBandwidth, 16'h0002);
    chk(powerOut.mode, MODE_SLEEP);
    chk(powerOut.clockOutEnable, 16'h0001);
    chk(clockWakeOut.slowClockSel, 16'h0001);
    chk(clockWakeOut.fastClockValid, 16'h0000);
    chk(clockWakeOut.tailCycles, 16'h0200);
    $display("test power-on done");
    cmd(16'hA05F);
    chk(rfOut.synthWord, 16'hA997);
    cmd(16'hA060);
    chk(rfOut.synthWord, 16'h9CA0);
    cmd(16'hAF40);
    chk(rfOut.synthWord, 16'h9CA0);
    cmd(16'hAF3F);
    chk(rfOut.synthWord, 16'hAB7F);
    HOST.shift(16'h009F, 8);
    HOST.close();
    chk(rfOut.bandSelect, 16'h0000);
    cmd(16'hC038);
    modulationIn = 1'b1;
    cmd(16'h9FF5);
    chk(rfOut.synthWord, 16'hBB1F);
    chk(rfOut.powerAttenDb, 16'h0015);
    chk(rfOut.loadCapHalfPf, 16'h0020);
    chk(rfOut.devSign, 16'h0001);
    chk(rfOut.devSteps, 16'h0006);
    $display("test frequency done");
    for (int i = 0; i < 4; i++) begin
      cmd(pw[i]);
      chk(powerOut.mode, md[i]);
      chk(powerOut.oscOn, (i < 2) ? 16'h1 : 16'h0);
      chk(powerOut.synthOn, (i == 0) ? 16'h1 : 16'h0);
    end
    $display("test modes done");
    cmd(16'hC2F5);
    cmd(16'hB09B);
    cmd(16'hE345);
    cmd(16'hC37F);
    chk(clockWakeOut.mcuClockDiv, 16'h0007);
    chk(clockWakeOut.batteryThreshDeciV, 16'h0019);
    chk(clockWakeOut.tailCycles, 16'h0080);
    chk(clockWakeOut.calibDisable, 16'h0001);
    chk(clockWakeOut.autoWakeOnIrq, 16'h0001);
    chk(clockWakeOut.holdAwakeAfterQueueIrq, 16'h0001);
    chk(clockWakeOut.wakeMantissa, 16'h3F45);
    chk(clockWakeOut.wakeExponent, 16'h0003);
    chk(clockWakeOut.wakeDivisor, 16'h0001);
    chk(rfOut.oscLowPower, 16'h0001);
    $display("test aux words done");
    cmd(16'hC800);
    cmd(16'hCE81);
    HOST.shift(16'h00C6, 8);
    repeat (4) HOST.shift(16'hFFFF, 16);
    HOST.close();
    chk(queueFull, 16'h0001);
    cmd(16'hCE00);
    chk(queueFull, 16'h0000);
    load(16'hFFFF, 16);
    cmd(16'hCE85);
    load(16'h0005, 4);
    cmd(16'hC038);
    chk(txActive, 16'h0001);
    chk(txBit, 16'h0001);
    chk(16'(irqCount), 16'h0000);
    cmd(16'hC030);
    load(16'h00FF, 8);
    cmd(16'hC038);
    chk(16'(irqCount), 16'h0001);
    $display("test queue done");
    print_verdict();
  end
endmodule
